/* File: pkg/scc_pkg.sv */
/*
  constants for the special-character codec: widths, status values,
  special-character codes, the K-symbol table and reset values.
  assumes symbols are written abcdei fghj with bit a in bit 9.
*/
package scc_pkg;
  // widths
  localparam int SYM_W = 10;
  localparam int CHR_W = 8;
  localparam int ST_W = 3;
  // number of table K symbols and the comma entry
  localparam int NUM_K = 12;
  localparam logic [3:0] COMMA_IDX = 4'h5;
  // receive status values
  localparam logic [2:0] ST_DATA = 3'h0;
  localparam logic [2:0] ST_SPECIAL = 3'h1;
  localparam logic [2:0] ST_NEG_COMMA = 3'h4;
  localparam logic [2:0] ST_POS_COMMA = 3'h5;
  localparam logic [2:0] ST_CODE_VIOL = 3'h6;
  localparam logic [2:0] ST_DISP_VIOL = 3'h7;
  // special-character codes (same in both code sets)
  localparam logic [7:0] C_EOF = 8'h22;
  localparam logic [7:0] C_CODE_VIOL = 8'hE0;
  localparam logic [7:0] C_NEG_COMMA = 8'hE1;
  localparam logic [7:0] C_POS_COMMA = 8'hE2;
  localparam logic [7:0] C_DISP_VIOL = 8'hE4;
  localparam logic [7:0] C_NONE = 8'h00;
  // negative-disparity forms of the violation symbols
  localparam logic [9:0] SYM_CV = 10'h278;
  localparam logic [9:0] SYM_DV = 10'h375;
  // negative-disparity forms: K28.0..K28.7, K23.7, K27.7, K29.7, K30.7
  localparam logic [9:0] K_NEG [NUM_K] = '{10'h0F4, 10'h0F9, 10'h0F5, 10'h0F3,
    10'h0F2, 10'h0FA, 10'h0F6, 10'h0F8, 10'h3A8, 10'h368, 10'h2E8, 10'h1E8};
  // alternate-set codes for the same entries
  localparam logic [7:0] K_ALT [NUM_K] = '{8'h1C, 8'h3C, 8'h5C, 8'h7C,
    8'h9C, 8'hBC, 8'hDC, 8'hFC, 8'hF7, 8'hFB, 8'hFD, 8'hFE};
  // structural sub-block limits on ones counts
  localparam logic [2:0] SIX_MIN = 3'h2;
  localparam logic [2:0] SIX_MAX = 3'h4;
  localparam logic [2:0] FOUR_MIN = 3'h1;
  localparam logic [2:0] FOUR_MAX = 3'h3;
  localparam logic [3:0] ONES_NEG = 4'h4;
  localparam logic [3:0] ONES_POS = 4'h6;
  // running disparity: 0 negative, 1 positive
  localparam logic RD_RESET = 1'b0;
  localparam logic [1:0] SYNC_RESET = 2'h0;
endpackage : scc_pkg

/* File: rtl/scc_codec.sv */
/*
  special-character encode and decode for one 8b/10b channel.
  assumes the host and the downstream data encoder share sys_clk_i;
  data characters are table-encoded outside, which reports whether
  the data symbol now on the line flips running disparity.
*/
`timescale 1ns/1ps
module scc_codec (
  // clock, reset, enable
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic clk_en_i,
  // host transmit side
  input wire logic tx_valid_i,
  input wire logic tx_char_control_i,
  input wire logic [7:0] tx_data_i,
  input wire logic tx_data_flip_i,
  // line transmit side
  output logic [9:0] tx_sym_o,
  output logic [7:0] tx_byte_o,
  output logic tx_special_o,
  output logic tx_rd_o,
  // line receive side
  input wire logic rx_valid_i,
  input wire logic [9:0] rx_sym_i,
  // configuration pin
  input wire logic decode_code_set_select_i,
  // host receive side
  output logic rx_valid_o,
  output logic [2:0] rx_char_status_o,
  output logic [7:0] rx_char_o,
  output logic [9:0] rx_sym_o,
  output logic rx_rd_o
);
  // all state of the codec
  typedef struct packed {
    logic [9:0] tx_sym;
    logic [7:0] tx_byte;
    logic tx_special;
    logic tx_rd;
    logic tx_eof_pend;
    logic [1:0] dsel_sync;
    logic rx_valid;
    logic [2:0] rx_status;
    logic [7:0] rx_char;
    logic [9:0] rx_sym;
    logic rx_rd;
  } scc_state_t;

  scc_state_t st_ff; // registered state
  scc_state_t nxt_st; // next state
  logic tcl_pos, tcl_neg; // class of symbol now on tx line
  logic rcl_pos, rcl_neg, rcl_ok; // class of received symbol
  logic tx_rd_now; // disparity after symbol now on tx line
  logic hit, hit_neg, wrong, alt; // receive table lookup
  logic [3:0] idx; // table entry that matched

  // pick symbol form for current disparity
  function automatic logic [9:0] pick(input logic [9:0] neg, input logic rd);
    return rd ? ~neg : neg;
  endfunction : pick

  // classify transmitted special symbol
  scc_sym_class u_tx_class (
    .sym_i(st_ff.tx_sym),
    .pos_o(tcl_pos),
    .neg_o(tcl_neg),
    .shape_ok_o()
  );

  // classify received symbol
  scc_sym_class u_rx_class (
    .sym_i(rx_sym_i),
    .pos_o(rcl_pos),
    .neg_o(rcl_neg),
    .shape_ok_o(rcl_ok)
  );

  // next-state logic for both directions
  always_comb begin
    nxt_st = st_ff;
    hit = 1'b0;
    hit_neg = 1'b0;
    idx = 4'h0;
    alt = st_ff.dsel_sync[1];
    // symbols with four or six ones flip disparity; data flip comes from outside
    tx_rd_now = st_ff.tx_rd ^ (st_ff.tx_special ? (tcl_pos | tcl_neg) : tx_data_flip_i);
    for (int i = 0; i < scc_pkg::NUM_K; i++) begin
      if (rx_sym_i == scc_pkg::K_NEG[i]) begin
        hit = 1'b1;
        hit_neg = 1'b1;
        idx = 4'(i);
      end else if (rx_sym_i == ~scc_pkg::K_NEG[i]) begin
        hit = 1'b1;
        idx = 4'(i);
      end
    end
    wrong = (hit_neg == st_ff.rx_rd);
    if (clk_en_i) begin
      // configuration pin passes two flops
      nxt_st.dsel_sync = {st_ff.dsel_sync[0], decode_code_set_select_i};
      // transmit: default is the fill comma
      nxt_st.tx_rd = tx_rd_now;
      nxt_st.tx_special = 1'b1;
      nxt_st.tx_byte = tx_data_i;
      nxt_st.tx_sym = pick(scc_pkg::K_NEG[scc_pkg::COMMA_IDX], tx_rd_now);
      if (tx_valid_i && tx_char_control_i) begin
        nxt_st.tx_eof_pend = 1'b0;
        if (tx_data_i == scc_pkg::C_NEG_COMMA) begin
          nxt_st.tx_sym = scc_pkg::K_NEG[scc_pkg::COMMA_IDX];
        end else if (tx_data_i == scc_pkg::C_POS_COMMA) begin
          nxt_st.tx_sym = ~scc_pkg::K_NEG[scc_pkg::COMMA_IDX];
        end else if (tx_data_i == scc_pkg::C_CODE_VIOL) begin
          nxt_st.tx_sym = pick(scc_pkg::SYM_CV, tx_rd_now);
        end else if (tx_data_i == scc_pkg::C_DISP_VIOL) begin
          nxt_st.tx_sym = pick(scc_pkg::SYM_DV, tx_rd_now);
        end else if (tx_data_i == scc_pkg::C_EOF) begin
          // comma by disparity already chosen; mark next char
          nxt_st.tx_eof_pend = 1'b1;
        end else begin
          // table entries in either code set; reserved codes keep fill
          for (int i = 0; i < scc_pkg::NUM_K; i++) begin
            if (tx_data_i == 8'(i) || tx_data_i == scc_pkg::K_ALT[i]) begin
              nxt_st.tx_sym = pick(scc_pkg::K_NEG[i], tx_rd_now);
            end
          end
        end
      end else if (tx_valid_i) begin
        // data character handed to the outside encoder
        nxt_st.tx_special = 1'b0;
        nxt_st.tx_eof_pend = 1'b0;
        if (st_ff.tx_eof_pend) begin
          nxt_st.tx_byte[0] = ~tx_rd_now;
        end
      end
      // receive
      nxt_st.rx_valid = rx_valid_i;
      if (rx_valid_i) begin
        nxt_st.rx_sym = rx_sym_i;
        nxt_st.rx_char = scc_pkg::C_NONE;
        nxt_st.rx_status = scc_pkg::ST_SPECIAL;
        if (rx_sym_i == scc_pkg::SYM_CV || rx_sym_i == ~scc_pkg::SYM_CV ||
            (!hit && !rcl_ok)) begin
          // not a table symbol
          if (alt) begin
            nxt_st.rx_status = scc_pkg::ST_CODE_VIOL;
          end else begin
            nxt_st.rx_char = scc_pkg::C_CODE_VIOL;
          end
        end else if (hit && wrong && idx == scc_pkg::COMMA_IDX) begin
          // comma against running disparity
          if (alt) begin
            nxt_st.rx_status = hit_neg ? scc_pkg::ST_NEG_COMMA : scc_pkg::ST_POS_COMMA;
            nxt_st.rx_char = scc_pkg::K_ALT[scc_pkg::COMMA_IDX];
          end else if (hit_neg) begin
            nxt_st.rx_char = scc_pkg::C_NEG_COMMA;
          end else begin
            nxt_st.rx_char = scc_pkg::C_POS_COMMA;
          end
        end else if (hit && wrong) begin
          // other special with wrong disparity
          if (alt) begin
            nxt_st.rx_status = scc_pkg::ST_DISP_VIOL;
          end else begin
            nxt_st.rx_char = scc_pkg::C_DISP_VIOL;
          end
        end else if (hit) begin
          nxt_st.rx_char = alt ? scc_pkg::K_ALT[idx] : {4'h0, idx};
        end else if ((rcl_pos && st_ff.rx_rd) || (rcl_neg && !st_ff.rx_rd)) begin
          // data symbol with wrong disparity
          if (alt) begin
            nxt_st.rx_status = scc_pkg::ST_DISP_VIOL;
          end else begin
            nxt_st.rx_char = scc_pkg::C_DISP_VIOL;
          end
        end else begin
          nxt_st.rx_status = scc_pkg::ST_DATA;
        end
        // disparity follows the symbol, good or bad
        if (rcl_pos) begin
          nxt_st.rx_rd = 1'b1;
        end else if (rcl_neg) begin
          nxt_st.rx_rd = 1'b0;
        end
      end
    end
  end

  // state register
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_ff <= '0;
      st_ff.tx_rd <= scc_pkg::RD_RESET;
      st_ff.rx_rd <= scc_pkg::RD_RESET;
      st_ff.dsel_sync <= scc_pkg::SYNC_RESET;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // outputs straight from the state register
  assign tx_sym_o = st_ff.tx_sym;
  assign tx_byte_o = st_ff.tx_byte;
  assign tx_special_o = st_ff.tx_special;
  assign tx_rd_o = st_ff.tx_rd;
  assign rx_valid_o = st_ff.rx_valid;
  assign rx_char_status_o = st_ff.rx_status;
  assign rx_char_o = st_ff.rx_char;
  assign rx_sym_o = st_ff.rx_sym;
  assign rx_rd_o = st_ff.rx_rd;

  // checks
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);

  property p_fill;
    clk_en_i && !tx_valid_i |=> tx_special_o &&
      tx_sym_o == pick(scc_pkg::K_NEG[scc_pkg::COMMA_IDX], tx_rd_o);
  endproperty
  a_fill: assert property (p_fill) else $error("fill not K28.5");

  property p_neg_comma;
    clk_en_i && tx_valid_i && tx_char_control_i && tx_data_i == scc_pkg::C_NEG_COMMA
      |=> tx_sym_o == scc_pkg::K_NEG[scc_pkg::COMMA_IDX];
  endproperty
  a_neg_comma: assert property (p_neg_comma) else $error("bad forced neg comma");

  property p_pos_comma;
    clk_en_i && tx_valid_i && tx_char_control_i && tx_data_i == scc_pkg::C_POS_COMMA
      |=> tx_sym_o == ~scc_pkg::K_NEG[scc_pkg::COMMA_IDX];
  endproperty
  a_pos_comma: assert property (p_pos_comma) else $error("bad forced pos comma");

  property p_eof_lsb;
    clk_en_i && tx_valid_i && tx_char_control_i && tx_data_i == scc_pkg::C_EOF ##1
      clk_en_i && tx_valid_i && !tx_char_control_i |=> tx_byte_o[0] == !tx_rd_o && !tx_special_o;
  endproperty
  a_eof_lsb: assert property (p_eof_lsb) else $error("eof next lsb wrong");

  property p_eof_sym;
    clk_en_i && tx_valid_i && tx_char_control_i && tx_data_i == scc_pkg::C_EOF
      |=> tx_sym_o == pick(scc_pkg::K_NEG[scc_pkg::COMMA_IDX], tx_rd_o);
  endproperty
  a_eof_sym: assert property (p_eof_sym) else $error("eof comma wrong");

  property p_rx_neg;
    clk_en_i && rx_valid_i && rx_rd_o && !st_ff.dsel_sync[1] &&
      rx_sym_i == scc_pkg::K_NEG[scc_pkg::COMMA_IDX]
      |=> rx_char_o == scc_pkg::C_NEG_COMMA && rx_char_status_o == scc_pkg::ST_SPECIAL;
  endproperty
  a_rx_neg: assert property (p_rx_neg) else $error("neg comma not reported");

  property p_rx_pos;
    clk_en_i && rx_valid_i && !rx_rd_o && !st_ff.dsel_sync[1] &&
      rx_sym_i == ~scc_pkg::K_NEG[scc_pkg::COMMA_IDX] |=> rx_char_o == scc_pkg::C_POS_COMMA;
  endproperty
  a_rx_pos: assert property (p_rx_pos) else $error("pos comma not reported");

  property p_rx_cv;
    clk_en_i && rx_valid_i && !st_ff.dsel_sync[1] && rx_sym_i == scc_pkg::SYM_CV
      |=> rx_char_o == scc_pkg::C_CODE_VIOL && rx_valid_o;
  endproperty
  a_rx_cv: assert property (p_rx_cv) else $error("code violation missed");

  property p_rx_alt;
    clk_en_i && rx_valid_i && !rx_rd_o && st_ff.dsel_sync[1] &&
      rx_sym_i == scc_pkg::K_NEG[0] |=> rx_char_o == scc_pkg::K_ALT[0];
  endproperty
  a_rx_alt: assert property (p_rx_alt) else $error("alternate decode wrong");

  property p_freeze;
    !clk_en_i |=> $stable(tx_sym_o) && $stable(rx_char_o) && $stable(rx_rd_o);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while disabled");
endmodule : scc_codec

/* File: rtl/scc_sym_class.sv */
/*
  classifies a 10-bit symbol by ones count: positive, negative or
  balanced disparity, and whether its sub-blocks are plausible.
  assumes purely combinational use by the codec.
*/
`timescale 1ns/1ps
module scc_sym_class (
  // symbol under test
  input wire logic [9:0] sym_i,
  // classification
  output logic pos_o,
  output logic neg_o,
  output logic shape_ok_o
);
  logic [2:0] six; // ones in abcdei
  logic [2:0] four; // ones in fghj
  logic [3:0] tot; // ones in whole symbol

  // count ones per sub-block and check limits
  always_comb begin
    six = 3'h0;
    four = 3'h0;
    for (int i = 4; i < 10; i++) begin
      six = six + {2'h0, sym_i[i]};
    end
    for (int i = 0; i < 4; i++) begin
      four = four + {2'h0, sym_i[i]};
    end
    tot = {1'b0, six} + {1'b0, four};
    pos_o = (tot == scc_pkg::ONES_POS);
    neg_o = (tot == scc_pkg::ONES_NEG);
    shape_ok_o = (six >= scc_pkg::SIX_MIN) && (six <= scc_pkg::SIX_MAX) &&
      (four >= scc_pkg::FOUR_MIN) && (four <= scc_pkg::FOUR_MAX) &&
      (tot >= scc_pkg::ONES_NEG) && (tot <= scc_pkg::ONES_POS);
  end
endmodule : scc_sym_class

/* File: testbench/scc_host_model.sv */
/*
  stand-in for the outside data encoder next to the host: reports
  whether the data character now shown flips running disparity.
  assumes the codec shows tx_special_o, tx_byte_o on one clock.
*/
`timescale 1ns/1ps
module scc_host_model (
  // codec transmit outputs
  input wire logic tx_special_i,
  input wire logic [7:0] tx_byte_i,
  // disparity flip back to the codec
  output logic tx_data_flip_o
);
  // odd byte parity stands in for an unbalanced data symbol
  assign tx_data_flip_o = tx_special_i ? 1'b0 : ^tx_byte_i;
endmodule : scc_host_model

/* File: testbench/tb_top.sv */
/*
  self-checking bench for the special-character codec.
  assumes one 200 MHz clock and the host model as data encoder.
*/
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin fails++; \
  $display("unexpected %s expected %h seen %h", nm, ex, got); end end
module tb_top;
  // clock, reset and design inputs
  logic sys_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic tx_valid_i = 1'b0;
  logic tx_char_control_i = 1'b0;
  logic [7:0] tx_data_i = 8'h00;
  logic rx_valid_i = 1'b0;
  logic [9:0] rx_sym_i = 10'h000;
  logic sel = 1'b0;
  logic clk_en = 1'b1;
  // design outputs
  logic flip, tx_special_o, tx_rd_o, rx_valid_o, rx_rd_o;
  logic [9:0] tx_sym_o, rx_sym_o;
  logic [7:0] tx_byte_o, rx_char_o;
  logic [2:0] rx_char_status_o;
  // bench state
  int fails = 0;
  int checked = 0;
  int cycles = 0;
  logic rd_tx = 1'b0;
  logic rd_rx = 1'b0;
  // clock at 5 ns period
  always #2.5 sys_clk_i = ~sys_clk_i;
  scc_codec i_dut (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .clk_en_i(clk_en),
    .tx_valid_i(tx_valid_i), .tx_char_control_i(tx_char_control_i),
    .tx_data_i(tx_data_i), .tx_data_flip_i(flip), .tx_sym_o(tx_sym_o),
    .tx_byte_o(tx_byte_o), .tx_special_o(tx_special_o), .tx_rd_o(tx_rd_o),
    .rx_valid_i(rx_valid_i), .rx_sym_i(rx_sym_i), .decode_code_set_select_i(sel),
    .rx_valid_o(rx_valid_o), .rx_char_status_o(rx_char_status_o),
    .rx_char_o(rx_char_o), .rx_sym_o(rx_sym_o), .rx_rd_o(rx_rd_o));
  scc_host_model i_host (.tx_special_i(tx_special_o), .tx_byte_i(tx_byte_o),
    .tx_data_flip_o(flip));
  // closing report
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : tally_and_finish
  // hang guard
  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      fails++;
      tally_and_finish();
    end
  end
  // one transmit character; checks disparity at its start
  task automatic tx_go(input logic v, input logic c, input logic [7:0] d);
    tx_valid_i = v;
    tx_char_control_i = c;
    tx_data_i = d;
    @(posedge sys_clk_i);
    #1;
    `CHK("tx_rd_o", rd_tx, tx_rd_o)
  endtask : tx_go
  // special symbol; forced ones ignore disparity
  task automatic tx_spec(input logic v, input logic [7:0] d, input logic [9:0] neg,
    input logic forced);
    logic [9:0] e;
    e = (forced || !rd_tx) ? neg : ~neg;
    tx_go(v, 1'b1, d);
    `CHK("tx_special_o", 1'b1, tx_special_o)
    `CHK("tx_sym_o", e, tx_sym_o)
    if ($countones(e) == 6 || $countones(e) == 4) rd_tx = ~rd_tx;
  endtask : tx_spec
  // data character handed to the outside encoder
  task automatic tx_dat(input logic [7:0] d, input logic [7:0] eb);
    tx_go(1'b1, 1'b0, d);
    `CHK("tx_special_o", 1'b0, tx_special_o)
    `CHK("tx_byte_o", eb, tx_byte_o)
    rd_tx = rd_tx ^ (^eb);
  endtask : tx_dat
  // one received symbol and its expected report
  task automatic rx_go(input logic [9:0] s, input logic [2:0] st, input logic [7:0] ch);
    rx_valid_i = 1'b1;
    rx_sym_i = s;
    @(posedge sys_clk_i);
    #1;
    if ($countones(s) == 6) rd_rx = 1'b1;
    else if ($countones(s) == 4) rd_rx = 1'b0;
    `CHK("rx_valid_o", 1'b1, rx_valid_o)
    `CHK("rx_char_status_o", st, rx_char_status_o)
    `CHK("rx_char_o", ch, rx_char_o)
    `CHK("rx_rd_o", rd_rx, rx_rd_o)
    `CHK("rx_sym_o", s, rx_sym_o)
  endtask : rx_go
  // fill, then every table code in both sets
  task automatic t_codes();
    tx_spec(1'b0, 8'h00, scc_pkg::K_NEG[5], 1'b0);
    tx_spec(1'b0, 8'h00, scc_pkg::K_NEG[5], 1'b0);
    tx_spec(1'b1, 8'h0C, scc_pkg::K_NEG[5], 1'b0);
    for (int i = 0; i < scc_pkg::NUM_K; i++) begin
      tx_spec(1'b1, 8'(i), scc_pkg::K_NEG[i], 1'b0);
      tx_spec(1'b1, scc_pkg::K_ALT[i], scc_pkg::K_NEG[i], 1'b0);
    end
    $display("test codes done");
  endtask : t_codes
  // forced commas and violations; the negative comma and the code violation at both disparities
  task automatic t_forced();
    tx_spec(1'b1, scc_pkg::C_NEG_COMMA, 10'h0FA, 1'b1);
    tx_spec(1'b1, scc_pkg::C_NEG_COMMA, 10'h0FA, 1'b1);
    tx_spec(1'b1, scc_pkg::C_CODE_VIOL, scc_pkg::SYM_CV, 1'b0);
    tx_spec(1'b1, scc_pkg::C_POS_COMMA, 10'h305, 1'b1);
    tx_spec(1'b1, scc_pkg::C_CODE_VIOL, scc_pkg::SYM_CV, 1'b0);
    tx_spec(1'b1, scc_pkg::C_DISP_VIOL, scc_pkg::SYM_DV, 1'b0);
    tx_spec(1'b1, scc_pkg::C_DISP_VIOL, scc_pkg::SYM_DV, 1'b0);
    $display("test forced done");
  endtask : t_forced
  // end of frame marks the next data character's low bit
  task automatic t_eof();
    tx_spec(1'b1, scc_pkg::C_EOF, scc_pkg::K_NEG[5], 1'b0);
    tx_spec(1'b0, 8'h00, scc_pkg::K_NEG[5], 1'b0);
    tx_dat(8'h95, {7'h4A, ~rd_tx});
    tx_spec(1'b1, scc_pkg::C_EOF, scc_pkg::K_NEG[5], 1'b0);
    tx_dat(8'h95, {7'h4A, ~rd_tx});
    tx_dat(8'h5A, 8'h5A);
    tx_valid_i = 1'b0;
    $display("test eof done");
  endtask : t_eof
  // receive decode in the chosen code set
  task automatic t_rx(input logic alt);
    logic [7:0] k;
    k = alt ? scc_pkg::K_ALT[5] : 8'h05;
    rx_go(scc_pkg::K_NEG[0], 3'h1, alt ? scc_pkg::K_ALT[0] : 8'h00);
    rx_go(10'h0FA, 3'h1, k);
    rx_go(10'h0FA, alt ? 3'h4 : 3'h1, alt ? k : 8'hE1);
    rx_go(10'h305, 3'h1, k);
    rx_go(10'h305, alt ? 3'h5 : 3'h1, alt ? k : 8'hE2);
    rx_go(scc_pkg::SYM_CV, alt ? 3'h6 : 3'h1, alt ? 8'h00 : 8'hE0);
    rx_go(10'h30B, alt ? 3'h7 : 3'h1, alt ? 8'h00 : 8'hE4);
    rx_go(10'h2AA, 3'h0, 8'h00);
    rx_valid_i = 1'b0;
    rx_sym_i = ~rx_sym_i;
    $display("test receive done");
  endtask : t_rx
  // clock enable low freezes every output
  task automatic t_freeze();
    logic [9:0] s;
    s = tx_sym_o;
    clk_en = 1'b0;
    rx_valid_i = 1'b1;
    rx_sym_i = scc_pkg::SYM_CV;
    tx_go(1'b1, 1'b1, scc_pkg::C_POS_COMMA);
    tx_go(1'b1, 1'b1, scc_pkg::C_POS_COMMA);
    `CHK("tx_sym_o", s, tx_sym_o)
    `CHK("tx_special_o", 1'b1, tx_special_o)
    `CHK("rx_valid_o", 1'b0, rx_valid_o)
    `CHK("rx_char_o", 8'h00, rx_char_o)
    `CHK("rx_rd_o", rd_rx, rx_rd_o)
    clk_en = 1'b1;
    rx_valid_i = 1'b0;
    $display("test freeze done");
  endtask : t_freeze
  // main sequence; stimulus never forms false-comma pairs
  initial begin
    repeat (6) @(posedge sys_clk_i);
    #1;
    `CHK("tx_special_o", 1'b0, tx_special_o)
    `CHK("tx_rd_o", 1'b0, tx_rd_o)
    `CHK("rx_rd_o", 1'b0, rx_rd_o)
    rst_b_i = 1'b1;
    t_codes();
    t_forced();
    t_freeze();
    t_eof();
    t_rx(1'b0);
    sel = 1'b1;
    repeat (3) @(posedge sys_clk_i);
    #1;
    `CHK("rx_valid_o", 1'b0, rx_valid_o)
    t_rx(1'b1);
    tally_and_finish();
  end
endmodule : tb_top
